// ### core/crcfb_pkg.sv
/*
  crcfb_pkg: constants and carriers for the crc seed/feedback register block.
  assumes a 32-bit APB register bus and a same-clock 16-bit data feed.
*/
package crcfb_pkg;
  localparam int unsigned DATA_W        = 32;
  localparam int unsigned ADDR_W        = 12;
  localparam int unsigned FEED_W        = 16;
  localparam int unsigned LEN_W         = 5;
  localparam int unsigned HALF_W        = 16;
  localparam logic [ADDR_W-1:0] OFS_VALUE = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_MASK  = 12'h004;
  localparam logic [DATA_W-1:0] RST_VALUE = 32'h00000000;
  localparam logic [DATA_W-1:0] RST_MASK  = 32'h00000000;
  localparam logic [DATA_W-1:0] RD_UNMAPPED = 32'h00000000;
  localparam logic MODE_LFSR = 1'b0;
  localparam logic MODE_IP   = 1'b1;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
    logic [3:0]        pstrb;
  } crcfb_apb_req_t;

  typedef struct packed {
    logic              valid;
    logic [FEED_W-1:0] data;
  } crcfb_feed_t;

  typedef struct packed {
    logic [DATA_W-1:0] value;
    logic [DATA_W-1:0] mask;
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
  } crcfb_state_t;

  localparam crcfb_state_t RST_STATE = '{
    value:   RST_VALUE,
    mask:    RST_MASK,
    prdata:  RD_UNMAPPED,
    pready:  1'b0,
    pslverr: 1'b0
  };
endpackage

// ### core/crcfb_regs.sv
/*
  crcfb_regs: running value and feedback mask registers of a dma crc generator,
  with the lfsr and one's-complement checksum datapath behind them.
  assumes mode select and polynomial length are held static by a control
  register elsewhere, and that the data feed runs on ref_clk.
*/
`timescale 1ns/1ps

// Overview of operation
// - writing the value register seeds the generator, replacing the accumulated result in the strobed byte lanes only.
// - reading the value register returns the present result without disturbing it.
// - in lfsr mode bits above the polynomial length read as zero.
// - in checksum mode the result sits in the low 16 bits.
// - in checksum mode the upper 16 bits always read zero.
// - in checksum mode a written value reads back one's-complemented.
// - in checksum mode the feedback mask does not affect computation.
// - in lfsr mode a set mask bit feeds xor into that stage.
// - in lfsr mode a clear mask bit passes the previous stage straight through.
// - both registers are 32-bit read/write and clear to zero at reset.
module crcfb_regs (
  input  wire logic                          ref_clk,
  input  wire logic                          srst,
  input  wire crcfb_pkg::crcfb_apb_req_t     apb_req,
  output logic [crcfb_pkg::DATA_W-1:0]       prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire crcfb_pkg::crcfb_feed_t        feed,
  input  wire logic                          crc_mode_select,
  input  wire logic [crcfb_pkg::LEN_W-1:0]   polynomial_length
);

  crcfb_pkg::crcfb_state_t state;
  crcfb_pkg::crcfb_state_t next_state;

  // bits 0..len kept, everything above forced low
  function automatic logic [crcfb_pkg::DATA_W-1:0] f_len_mask(
    input logic [crcfb_pkg::LEN_W-1:0] len
  );
    logic [crcfb_pkg::LEN_W-1:0] sh;
    sh = 5'h1F - len;
    return 32'hFFFFFFFF >> sh;
  endfunction

  function automatic logic [crcfb_pkg::DATA_W-1:0] f_merge(
    input logic [crcfb_pkg::DATA_W-1:0] old_v,
    input logic [crcfb_pkg::DATA_W-1:0] wdata,
    input logic [3:0]                   strb
  );
    logic [crcfb_pkg::DATA_W-1:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = wdata[8*b +: 8];
      end
    end
    return r;
  endfunction

  // msb-first shift of one feed word through a galois lfsr
  function automatic logic [crcfb_pkg::DATA_W-1:0] f_lfsr(
    input logic [crcfb_pkg::DATA_W-1:0] cur,
    input logic [crcfb_pkg::DATA_W-1:0] fbmask,
    input logic [crcfb_pkg::LEN_W-1:0]  len,
    input logic [crcfb_pkg::FEED_W-1:0] din
  );
    logic [crcfb_pkg::DATA_W-1:0] s;
    logic [crcfb_pkg::DATA_W-1:0] shifted;
    logic                         fb;
    s = cur;
    for (int i = crcfb_pkg::FEED_W - 1; i >= 0; i--) begin
      fb = s[len] ^ din[i];
      shifted = {s[crcfb_pkg::DATA_W-2:0], 1'b0};
      s = (shifted ^ (fbmask & {crcfb_pkg::DATA_W{fb}})) & f_len_mask(len);
    end
    return s;
  endfunction

  // end-around-carry add, the checksum accumulator step
  function automatic logic [crcfb_pkg::HALF_W-1:0] f_ip_add(
    input logic [crcfb_pkg::HALF_W-1:0] a,
    input logic [crcfb_pkg::HALF_W-1:0] b
  );
    logic [crcfb_pkg::HALF_W:0] sum;
    logic [crcfb_pkg::HALF_W:0] wrap;
    sum  = {1'b0, a} + {1'b0, b};
    wrap = {1'b0, sum[crcfb_pkg::HALF_W-1:0]} + {16'h0000, sum[crcfb_pkg::HALF_W]};
    return wrap[crcfb_pkg::HALF_W-1:0];
  endfunction

  // software view of the running value
  function automatic logic [crcfb_pkg::DATA_W-1:0] f_view(
    input logic [crcfb_pkg::DATA_W-1:0] v,
    input logic                         mode,
    input logic [crcfb_pkg::LEN_W-1:0]  len
  );
    if (mode == crcfb_pkg::MODE_IP) begin
      return {16'h0000, ~v[crcfb_pkg::HALF_W-1:0]};
    end
    return v & f_len_mask(len);
  endfunction

  logic setup_phase;
  logic access_done;
  logic hit_value;
  logic hit_mask;
  logic lfsr_mode;
  logic [crcfb_pkg::DATA_W-1:0] len_mask;
  logic [crcfb_pkg::DATA_W-1:0] merged_value;

  assign lfsr_mode   = (crc_mode_select == crcfb_pkg::MODE_LFSR);
  assign len_mask    = f_len_mask(polynomial_length);
  // byte-merged write word as a net, a function result cannot be sliced directly
  assign merged_value = f_merge(state.value, apb_req.pwdata, apb_req.pstrb);
  assign setup_phase = apb_req.psel && !apb_req.penable;
  assign access_done = apb_req.psel && apb_req.penable && state.pready;
  assign hit_value   = (apb_req.paddr == crcfb_pkg::OFS_VALUE);
  assign hit_mask    = (apb_req.paddr == crcfb_pkg::OFS_MASK);

  always_comb begin
    next_state = state;
    next_state.pready = 1'b0;

    // feed first; a seed write in the same cycle overrides it below
    if (feed.valid) begin
      if (lfsr_mode) begin
        next_state.value = f_lfsr(state.value, state.mask, polynomial_length, feed.data);
      end else begin
        // mask ignored on this path
        next_state.value = {16'h0000, f_ip_add(state.value[crcfb_pkg::HALF_W-1:0], feed.data)};
      end
    end

    // answer one cycle after setup; read data is captured there
    if (setup_phase) begin
      next_state.pready  = 1'b1;
      next_state.pslverr = !(hit_value || hit_mask);
      if (hit_value) begin
        next_state.prdata = f_view(state.value, crc_mode_select, polynomial_length);
      end else if (hit_mask) begin
        next_state.prdata = state.mask;
      end else begin
        next_state.prdata = crcfb_pkg::RD_UNMAPPED;
      end
    end

    if (access_done && apb_req.pwrite) begin
      if (hit_value) begin
        if (lfsr_mode) begin
          next_state.value = merged_value & len_mask;
        end else begin
          // stored raw, so the read view comes back complemented
          next_state.value = {16'h0000,
            merged_value[crcfb_pkg::HALF_W-1:0]};
        end
      end else if (hit_mask) begin
        next_state.mask = f_merge(state.mask, apb_req.pwdata, apb_req.pstrb);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state <= crcfb_pkg::RST_STATE;
    end else begin
      state <= next_state;
    end
  end

  assign prdata  = state.prdata;
  assign pready  = state.pready;
  assign pslverr = state.pslverr;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  logic full_wr_value;
  assign full_wr_value = access_done && apb_req.pwrite && hit_value && (apb_req.pstrb == 4'hF);

  property p_seed_lfsr;
    full_wr_value && lfsr_mode |=> state.value == ($past(apb_req.pwdata) & $past(len_mask));
  endproperty
  a_seed_lfsr: assert property (p_seed_lfsr) else $error("seed write not loaded");

  property p_read_no_side_effect;
    apb_req.psel && !apb_req.pwrite && hit_value && !feed.valid |=> $stable(state.value);
  endproperty
  a_read_no_side_effect: assert property (p_read_no_side_effect) else $error("read disturbed value");

  property p_lfsr_high_zero;
    setup_phase && hit_value && lfsr_mode ##1 $stable(polynomial_length)
      |-> (prdata & ~len_mask) == 32'h00000000;
  endproperty
  a_lfsr_high_zero: assert property (p_lfsr_high_zero) else $error("bits above length not zero");

  property p_ip_upper_zero;
    setup_phase && hit_value && !lfsr_mode |=> prdata[31:16] == 16'h0000;
  endproperty
  a_ip_upper_zero: assert property (p_ip_upper_zero) else $error("checksum upper half not zero");

  property p_ip_low_result;
    setup_phase && hit_value && !lfsr_mode |=> prdata[15:0] == ~$past(state.value[15:0]);
  endproperty
  a_ip_low_result: assert property (p_ip_low_result) else $error("checksum low half wrong");

  property p_ip_write_readback;
    full_wr_value && !lfsr_mode ##1 !feed.valid && !apb_req.psel
      ##1 (setup_phase && hit_value && !lfsr_mode)
      |=> prdata == {16'h0000, ~$past(apb_req.pwdata[15:0], 3)};
  endproperty
  a_ip_write_readback: assert property (p_ip_write_readback) else $error("ip readback not complemented");

  property p_ip_mask_unused;
    feed.valid && !lfsr_mode && !(access_done && apb_req.pwrite && hit_value)
      |=> state.value[15:0] == f_ip_add($past(state.value[15:0]), $past(feed.data));
  endproperty
  a_ip_mask_unused: assert property (p_ip_mask_unused) else $error("checksum step wrong");

  property p_single_stage_xor;
    feed.valid && lfsr_mode && state.mask == 32'h00000001 && polynomial_length == 5'h00
      && !(access_done && apb_req.pwrite)
      |=> state.value[0] == ^{$past(state.value[0]), $past(feed.data)};
  endproperty
  a_single_stage_xor: assert property (p_single_stage_xor) else $error("xor feedback not applied");

  property p_plain_shift;
    feed.valid && lfsr_mode && state.mask == 32'h00000000 && !(access_done && apb_req.pwrite)
      |=> state.value == (($past(state.value) << 16) & $past(len_mask));
  endproperty
  a_plain_shift: assert property (p_plain_shift) else $error("cleared mask did not plain shift");

  property p_reset_clear;
    $past(srst) |-> state.value == 32'h00000000 && state.mask == 32'h00000000 && !pready;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("registers not cleared by reset");

  property p_mask_write;
    access_done && apb_req.pwrite && hit_mask && apb_req.pstrb == 4'hF
      |=> state.mask == $past(apb_req.pwdata);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask write not stored");

  property p_mode_static;
    setup_phase && hit_value ##1 $stable(crc_mode_select) && crc_mode_select == crcfb_pkg::MODE_IP
      |-> prdata[31:16] == 16'h0000;
  endproperty
  a_mode_static: assert property (p_mode_static) else $error("mode input not honoured");

  property p_pready_pulse;
    setup_phase |=> pready ##1 !pready;
  endproperty
  a_pready_pulse: assert property (p_pready_pulse) else $error("pready not a single-cycle answer");

  // bus side: refusal, answer timing, read data holding
  property p_unmapped_error;
    setup_phase && !(hit_value || hit_mask)
      |=> pslverr && prdata == crcfb_pkg::RD_UNMAPPED;
  endproperty
  a_unmapped_error: assert property (p_unmapped_error) else $error("unmapped access not refused");

  property p_mapped_no_error;
    setup_phase && (hit_value || hit_mask)
      |=> !pslverr;
  endproperty
  a_mapped_no_error: assert property (p_mapped_no_error) else $error("mapped access flagged as error");

  property p_unmapped_write_ignored;
    access_done && apb_req.pwrite && !(hit_value || hit_mask) && !feed.valid
      |=> $stable(state.value) && $stable(state.mask);
  endproperty
  a_unmapped_write_ignored: assert property (p_unmapped_write_ignored) else $error("unmapped write took effect");

  // zero wait states: a master that reaches access is answered at once
  property p_access_answered;
    apb_req.psel && apb_req.penable
      |-> pready;
  endproperty
  a_access_answered: assert property (p_access_answered) else $error("access phase left unanswered");

  property p_pready_after_setup;
    pready
      |-> $past(setup_phase);
  endproperty
  a_pready_after_setup: assert property (p_pready_after_setup) else $error("pready without a setup cycle");

  // software may sample read data late, so it must not wander between transfers
  property p_prdata_holds;
    !setup_phase
      |=> $stable(prdata) && $stable(pslverr);
  endproperty
  a_prdata_holds: assert property (p_prdata_holds) else $error("read data changed outside setup");

  // contents move only on feed words and mapped writes
  property p_value_untouched;
    !feed.valid && !(access_done && apb_req.pwrite && hit_value)
      |=> $stable(state.value);
  endproperty
  a_value_untouched: assert property (p_value_untouched) else $error("value changed with no cause");

  property p_mask_untouched;
    !(access_done && apb_req.pwrite && hit_mask)
      |=> $stable(state.mask);
  endproperty
  a_mask_untouched: assert property (p_mask_untouched) else $error("mask changed with no write");

  property p_mask_read;
    setup_phase && hit_mask
      |=> prdata == $past(state.mask);
  endproperty
  a_mask_read: assert property (p_mask_read) else $error("mask read data wrong");

  property p_mask_byte_write;
    access_done && apb_req.pwrite && hit_mask && apb_req.pstrb == 4'h1
      |=> state.mask[31:8] == $past(state.mask[31:8]) && state.mask[7:0] == $past(apb_req.pwdata[7:0]);
  endproperty
  a_mask_byte_write: assert property (p_mask_byte_write) else $error("mask byte lane merge wrong");

  // checksum mode keeps the upper half clear whatever arrives
  property p_ip_feed_upper_zero;
    feed.valid && !lfsr_mode
      |=> state.value[31:16] == 16'h0000;
  endproperty
  a_ip_feed_upper_zero: assert property (p_ip_feed_upper_zero) else $error("checksum upper half set");

  property p_ip_write_stored;
    full_wr_value && !lfsr_mode
      |=> state.value == {16'h0000, $past(apb_req.pwdata[15:0])};
  endproperty
  a_ip_write_stored: assert property (p_ip_write_stored) else $error("checksum seed not stored");

  // length held steady, so the kept-bit window is the same on both edges
  property p_lfsr_shift_trimmed;
    feed.valid && lfsr_mode ##1 $stable(polynomial_length)
      |-> (state.value & ~len_mask) == 32'h00000000;
  endproperty
  a_lfsr_shift_trimmed: assert property (p_lfsr_shift_trimmed) else $error("shift left bits above length");

  // the bench leaves one idle cycle after each transfer, hence the gap of two
  c_seed_write: cover property (full_wr_value ##2 setup_phase && hit_value);
  c_ip_feed: cover property (!lfsr_mode && feed.valid ##2 setup_phase && hit_value);
  c_len_zero_xor: cover property (lfsr_mode && feed.valid && polynomial_length == 5'h00);
  c_lfsr_feed: cover property (lfsr_mode && feed.valid && state.mask != 32'h00000000);
  c_unmapped: cover property (access_done && state.pslverr);

endmodule

// ### dv/crcfb_regs_tb.sv
/*
  crcfb_regs_tb: self-checking bench for the crc running value and feedback
  mask registers, driven over apb and the 16-bit data feed.
  assumes crcfb_pkg is compiled first; assertions live in the design itself.
*/
`timescale 1ns/1ps
module crcfb_regs_tb;
  logic                                ref_clk = 1'b0;
  logic                                srst;
  crcfb_pkg::crcfb_apb_req_t           apb_req;
  logic [crcfb_pkg::DATA_W-1:0]        prdata;
  logic                                pready;
  logic                                pslverr;
  crcfb_pkg::crcfb_feed_t              feed;
  logic                                crc_mode_select;
  logic [crcfb_pkg::LEN_W-1:0]         polynomial_length;
  int                                  err_total = 0;
  int                                  samples_checked = 0;
  logic [31:0]                         rd;
  logic                                er;

  always #2.5 ref_clk = ~ref_clk;

  crcfb_regs crcfb_regs_inst (
    .ref_clk           (ref_clk),
    .srst              (srst),
    .apb_req           (apb_req),
    .prdata            (prdata),
    .pready            (pready),
    .pslverr           (pslverr),
    .feed              (feed),
    .crc_mode_select   (crc_mode_select),
    .polynomial_length (polynomial_length)
  );

  task automatic conclude();
    if (err_total == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // entered just after a rising edge; one idle cycle follows each transfer
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    apb_req.psel    <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.pwrite  <= wr;
    apb_req.paddr   <= a;
    apb_req.pwdata  <= d;
    apb_req.pstrb   <= s;
    @(posedge ref_clk);
    apb_req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) chk(32'h0000DEAD, 32'h00000000);
    rd = prdata;
    er = pslverr;
    apb_req.psel    <= 1'b0;
    apb_req.penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000, 4'h0);
    chk(rd, exp);
    chk({31'h0, er}, 32'h00000000);
  endtask

  task automatic feed_words(input logic [15:0] w0, input logic [15:0] w1);
    feed <= '{valid: 1'b1, data: w0};
    @(posedge ref_clk);
    feed <= '{valid: 1'b1, data: w1};
    @(posedge ref_clk);
    feed.valid <= 1'b0;
    @(posedge ref_clk);
  endtask

  // msb-first shift with per-stage xor enable, trimmed to the kept length
  function automatic logic [31:0] lfsr(input logic [31:0] s, input logic [31:0] m, input int len,
                                       input logic [15:0] d);
    logic [31:0] lm;
    logic        fb;
    lm = (32'h00000001 << (len + 1)) - 32'h00000001;
    for (int i = 15; i >= 0; i--) begin
      fb = s[len] ^ d[i];
      s = ((s << 1) ^ (m & {32{fb}})) & lm;
    end
    return s;
  endfunction

  function automatic logic [15:0] ipadd(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] t;
    t = {1'b0, a} + {1'b0, b};
    return t[15:0] + {15'h0, t[16]};
  endfunction

  task automatic t_reset();
    rd_chk(crcfb_pkg::OFS_VALUE, 32'h00000000);
    rd_chk(crcfb_pkg::OFS_MASK, 32'h00000000);
    apb(1'b1, 12'h008, 32'hFFFFFFFF, 4'hF);
    apb(1'b0, 12'h008, 32'h00000000, 4'h0);
    chk(rd, crcfb_pkg::RD_UNMAPPED);
    chk({31'h0, er}, 32'h00000001);
    rd_chk(crcfb_pkg::OFS_MASK, 32'h00000000);
  endtask

  task automatic t_regs();
    apb(1'b1, crcfb_pkg::OFS_MASK, 32'hA5A5F00F, 4'hF);
    rd_chk(crcfb_pkg::OFS_MASK, 32'hA5A5F00F);
    apb(1'b1, crcfb_pkg::OFS_MASK, 32'h123456FF, 4'h1);
    rd_chk(crcfb_pkg::OFS_MASK, 32'hA5A5F0FF);
    apb(1'b1, crcfb_pkg::OFS_VALUE, 32'h89ABCDEF, 4'hF);
    rd_chk(crcfb_pkg::OFS_VALUE, 32'h89ABCDEF);
    rd_chk(crcfb_pkg::OFS_VALUE, 32'h89ABCDEF);
    polynomial_length <= 5'd7;
    apb(1'b1, crcfb_pkg::OFS_VALUE, 32'hFFFFFFFF, 4'hF);
    rd_chk(crcfb_pkg::OFS_VALUE, 32'h000000FF);
  endtask

  task automatic t_lfsr();
    logic [31:0] e;
    polynomial_length <= 5'd31;
    apb(1'b1, crcfb_pkg::OFS_MASK, 32'h04C11DB7, 4'hF);
    apb(1'b1, crcfb_pkg::OFS_VALUE, 32'hFFFFFFFF, 4'hF);
    feed_words(16'h1234, 16'hABCD);
    e = lfsr(lfsr(32'hFFFFFFFF, 32'h04C11DB7, 31, 16'h1234), 32'h04C11DB7, 31, 16'hABCD);
    rd_chk(crcfb_pkg::OFS_VALUE, e);
    apb(1'b1, crcfb_pkg::OFS_VALUE, 32'h0000C3A5, 4'hF);
    rd_chk(crcfb_pkg::OFS_VALUE, 32'h0000C3A5);
    polynomial_length <= 5'd15;
    apb(1'b1, crcfb_pkg::OFS_MASK, 32'h00000000, 4'hF);
    feed_words(16'h8001, 16'h0000);
    e = lfsr(lfsr(32'h0000C3A5, 32'h00000000, 15, 16'h8001), 32'h00000000, 15, 16'h0000);
    rd_chk(crcfb_pkg::OFS_VALUE, e);
    // one kept stage fed back onto itself: the result is the running parity
    polynomial_length <= 5'd0;
    apb(1'b1, crcfb_pkg::OFS_MASK, 32'h00000001, 4'hF);
    apb(1'b1, crcfb_pkg::OFS_VALUE, 32'h00000000, 4'hF);
    feed_words(16'h0001, 16'h0003);
    rd_chk(crcfb_pkg::OFS_VALUE, 32'h00000001);
  endtask

  // reset in mid-run, with both registers holding non-zero values
  task automatic t_rst2();
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    rd_chk(crcfb_pkg::OFS_VALUE, 32'h00000000);
    rd_chk(crcfb_pkg::OFS_MASK, 32'h00000000);
  endtask

  // same seed and words under two masks must land on the same checksum
  task automatic t_ip(input logic [31:0] m);
    logic [15:0] s;
    crc_mode_select <= crcfb_pkg::MODE_IP;
    apb(1'b1, crcfb_pkg::OFS_MASK, m, 4'hF);
    rd_chk(crcfb_pkg::OFS_MASK, m);
    apb(1'b1, crcfb_pkg::OFS_VALUE, 32'h12345678, 4'hF);
    rd_chk(crcfb_pkg::OFS_VALUE, 32'h0000A987);
    feed_words(16'hFFFF, 16'hBEEF);
    s = ipadd(ipadd(16'h5678, 16'hFFFF), 16'hBEEF);
    rd_chk(crcfb_pkg::OFS_VALUE, {16'h0000, ~s});
  endtask

  initial begin
    srst              = 1'b1;
    apb_req           = '0;
    feed              = '0;
    crc_mode_select   = crcfb_pkg::MODE_LFSR;
    polynomial_length = 5'd31;
    repeat (20) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    t_reset();
    t_regs();
    t_lfsr();
    t_rst2();
    t_ip(32'h00000000);
    t_ip(32'hFFFFFFFF);
    conclude();
  end

  initial begin
    repeat (5000) @(posedge ref_clk);
    err_total++;
    conclude();
  end
endmodule
